//--- design/cqpm_mapper_tx.sv
// Purpose: coherent payload mapper with pilot insertion and tx request handling
// Assumes: fch symbols, pn generator and ofdm modulator live outside
// Notes: one stream word per active carrier; stream passes a two-entry buffer
// Functional notes
// - 16-QAM only when supported and FCC band
// - four bits per point, d1d0 I, d3d2 Q
// - 16-QAM point scaled by one over sqrt ten
// - pilots only in payload data symbols
// - pilot position offset plus spacing i plus 2j
// - carriers per symbol 36, 16, 72
// - pilot spacing 12, 8, 12
// - pilot and symbol index ranges
// - pilot offset 6 CENELEC, 36 FCC
// - absolute bin is first bin plus carrier
// - active list drops masked and inactive carriers
// - pilots QPSK from PN bit pairs
// - pilots take PN outputs in ascending order
// - earlier PN bit LSB, later bit MSB
// - reference symbols framed like other symbols
// - pilots same power as data tones
// - frame request sends frame, confirms success
// - frame while listening: drop, busy receiving
// - frame while transmitting: drop, busy transmitting
// - invalid frame request: drop, failed
// - ack request sends frame or fails
// - ack while listening or sending: busy status
// - QPSK 00,01,11,10 give 0,90,180,270 degrees
`timescale 1ns/1ps
`include "cqpm_defines.svh"

module cqpm_mapper_tx (
  // clock and reset
  input  wire logic              core_clk_in,
  input  wire logic              rst_in,
  // configuration
  input  wire logic [1:0]        band_sel_in,
  input  wire logic              qam16_supported_in,
  input  wire logic              receive_listen_state_in,
  input  wire logic [71:0]       carrier_active_in,
  // frame request and confirm
  input  wire logic              frame_tx_request_in,
  input  wire logic              frame_qam16_in,
  input  wire logic [9:0]        frame_data_symbols_in,
  output logic                   frame_tx_confirm_out,
  output logic [1:0]             frame_tx_status_out,
  // ack request and confirm
  input  wire logic              ack_tx_request_in,
  output logic                   ack_tx_confirm_out,
  output logic [1:0]             ack_tx_status_out,
  output logic                   tx_busy_out,
  // payload bits
  input  wire logic              data_valid_in,
  input  wire logic [3:0]        data_bits_in,
  output logic                   data_ready_out,
  // pilot pn bits
  input  wire logic              pn_valid_in,
  input  wire logic [1:0]        pn_bits_in,
  output logic                   pn_ready_out,
  // mapped carrier stream
  output logic                   sym_valid_out,
  output cqpm_pkg::cqpm_word_s   sym_word_out,
  input  wire logic              sym_ready_in
);

  cqpm_pkg::cqpm_state_e state;  // control state
  logic [1:0]           band_q;     // band of the running frame
  logic                 qam_q;      // payload uses 16-qam
  logic [9:0]           nsym_q;     // data symbols in frame
  logic [9:0]           sym_j;      // current data symbol
  logic [71:0]          act_q;      // active carrier flags
  logic [6:0]           mact_q;     // active carrier count
  logic [71:0]          pil_mask;   // pilots by active position
  logic [6:0]           pos;        // pilot position under reduction
  logic [6:0]           base;       // reduced start of the current symbol
  logic [6:0]           acc;        // i times spacing
  logic                 first_pil;  // next placement is pilot 0
  logic [6:0]           car_k;      // carrier index in band
  logic [6:0]           act_a;      // index among active carriers
  logic                 ref_mode;   // scanning reference symbols
  logic                 ref_cnt;    // 0 inverted, 1 normal reference
  logic                 is_ack;     // running request is an ack
  logic [3:0]           data_hold;  // held payload bits
  logic                 data_hv;    // payload hold valid
  logic [1:0]           pn_hold;    // held pn pair
  logic                 pn_hv;      // pn hold valid
  cqpm_pkg::cqpm_word_s buf1;       // second buffer entry
  logic                 buf1_v;     // second entry valid

  // band lookup
  logic [1:0]  band_use;
  logic [6:0]  lk_m;
  logic [6:0]  lk_sp;
  logic [6:0]  lk_off;
  logic [7:0]  lk_first;
  logic [71:0] lk_range;
  logic [6:0]  req_mact;
  logic        frame_bad;

  // scan step
  logic                 cur_act;
  logic                 cur_pil;
  logic                 can_go;
  logic                 push_req;
  logic                 push_ok;
  logic                 pop;
  logic                 data_take;
  logic                 pn_take;
  cqpm_pkg::cqpm_word_s push_word;
  logic                 next_data_hv;
  logic                 next_pn_hv;

  // quarter-turn psk point; pilots and QPSK data use this amplitude
  function automatic logic [31:0] qpsk_point(input logic [1:0] code);
    logic signed [15:0] a;
    a = `CQPM_UNIT;
    unique case (code)
      2'h0: qpsk_point = {a, 16'sh0000};        // 0 degrees
      2'h1: qpsk_point = {16'sh0000, a};        // 90 degrees
      2'h3: qpsk_point = {-a, 16'sh0000};       // 180 degrees
      2'h2: qpsk_point = {16'sh0000, -a};       // 270 degrees
    endcase
  endfunction

  // 16-qam axis level, already scaled by 1/sqrt(10)
  function automatic logic signed [15:0] qam_level(input logic [1:0] b);
    unique case (b)
      2'h0: qam_level = -`CQPM_QAM_L3;
      2'h2: qam_level = -`CQPM_QAM_L1;
      2'h3: qam_level = `CQPM_QAM_L1;
      2'h1: qam_level = `CQPM_QAM_L3;
    endcase
  endfunction

  // band table: idle looks at the request, otherwise the latched band
  always_comb
  begin
    band_use = (state == cqpm_pkg::CQPM_S_IDLE) ? band_sel_in : band_q;
    lk_m     = 7'h00;
    lk_sp    = 7'h01;
    lk_off   = 7'h00;
    lk_first = 8'h00;
    unique case (band_use)
      `CQPM_BAND_CEN_A:
      begin
        lk_m     = `CQPM_M_CEN_A;
        lk_sp    = `CQPM_SP_CEN_A;
        lk_off   = `CQPM_OFF_CEN;
        lk_first = `CQPM_FIRST_CEN_A;
      end
      `CQPM_BAND_CEN_B:
      begin
        lk_m     = `CQPM_M_CEN_B;
        lk_sp    = `CQPM_SP_CEN_B;
        lk_off   = `CQPM_OFF_CEN;
        lk_first = `CQPM_FIRST_CEN_B;
      end
      `CQPM_BAND_FCC:
      begin
        lk_m     = `CQPM_M_FCC;
        lk_sp    = `CQPM_SP_FCC;
        lk_off   = `CQPM_OFF_FCC;
        lk_first = `CQPM_FIRST_FCC;
      end
      default: lk_m = 7'h00;           // unused code: no carriers
    endcase
  end

  // active count of the requested band; never above its carrier count
  always_comb
  begin
    lk_range = (72'h1 << lk_m) - 72'h1;
    req_mact = 7'($countones(carrier_active_in & lk_range));
    frame_bad = (lk_m == 7'h00) || (req_mact == 7'h00) || (frame_data_symbols_in == 10'h000)
             || (frame_qam16_in && !(qam16_supported_in && band_sel_in == `CQPM_BAND_FCC));
  end

  // current carrier: active list is the band scan minus masked ones
  always_comb
  begin
    cur_act   = act_q[car_k];
    cur_pil   = cur_act && !ref_mode && pil_mask[act_a];
    data_take = 1'b0;
    pn_take   = 1'b0;
    can_go    = 1'b1;
    push_req  = 1'b0;
    push_word = '0;
    push_word.bin       = lk_first + {1'b0, car_k};
    push_word.sym_start = (act_a == 7'h00);
    if (state == cqpm_pkg::CQPM_S_SCAN && cur_act)
    begin
      if (ref_mode)
      begin
        // reference symbols go out as ordinary framed symbols
        can_go         = !buf1_v;
        push_word.kind = ref_cnt ? cqpm_pkg::CQPM_KIND_REF : cqpm_pkg::CQPM_KIND_REF_INV;
        push_word.re   = ref_cnt ? `CQPM_UNIT : -`CQPM_UNIT;
        push_word.im   = 16'sh0000;
      end
      else if (cur_pil)
      begin
        // pilots take pn pairs in ascending carrier order
        can_go         = !buf1_v && pn_hv;
        pn_take        = can_go;
        push_word.kind = cqpm_pkg::CQPM_KIND_PILOT;
        {push_word.re, push_word.im} = qpsk_point({pn_hold[1], pn_hold[0]});
      end
      else
      begin
        can_go         = !buf1_v && data_hv;
        data_take      = can_go;
        push_word.kind = cqpm_pkg::CQPM_KIND_DATA;
        if (qam_q)
        begin
          push_word.re = qam_level(data_hold[1:0]);
          push_word.im = qam_level(data_hold[3:2]);
        end
        else
        begin
          {push_word.re, push_word.im} = qpsk_point(data_hold[1:0]);
        end
      end
      push_req = can_go;
    end
    else if (state == cqpm_pkg::CQPM_S_ACK)
    begin
      push_req       = !buf1_v;
      push_word.kind = cqpm_pkg::CQPM_KIND_ACK;
      push_word.bin  = lk_first;
      push_word.sym_start = 1'b1;
    end
    push_ok = push_req && !buf1_v;
    pop     = sym_valid_out && sym_ready_in;
  end

  // payload and pn holding registers; ready is the inverse of full
  always_comb
  begin
    next_data_hv = (data_hv && !data_take) || (data_valid_in && data_ready_out);
    next_pn_hv   = (pn_hv && !pn_take) || (pn_valid_in && pn_ready_out);
  end

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      data_hv        <= 1'b0;
      data_hold      <= 4'h0;
      data_ready_out <= 1'b0;
      pn_hv          <= 1'b0;
      pn_hold        <= 2'h0;
      pn_ready_out   <= 1'b0;
    end
    else
    begin
      data_hv        <= next_data_hv;
      data_ready_out <= !next_data_hv;
      pn_hv          <= next_pn_hv;
      pn_ready_out   <= !next_pn_hv;
      if (data_valid_in && data_ready_out)
      begin
        data_hold <= data_bits_in;
      end
      if (pn_valid_in && pn_ready_out)
      begin
        pn_hold <= pn_bits_in;    // bit 0 is the earlier pn bit
      end
    end
  end

  // two-entry output buffer; head entry drives the stream directly
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      sym_valid_out <= 1'b0;
      sym_word_out  <= '0;
      buf1          <= '0;
      buf1_v        <= 1'b0;
    end
    else if (pop)
    begin
      // head leaves; second entry or new word moves up
      if (buf1_v)
      begin
        sym_word_out <= buf1;
        buf1_v       <= 1'b0;
      end
      else if (push_ok)
      begin
        sym_word_out <= push_word;
      end
      else
      begin
        sym_valid_out <= 1'b0;
      end
    end
    else if (push_ok)
    begin
      if (!sym_valid_out)
      begin
        sym_word_out  <= push_word;
        sym_valid_out <= 1'b1;
      end
      else
      begin
        buf1   <= push_word;
        buf1_v <= 1'b1;
      end
    end
  end

  // request handling, pilot planning and carrier scan
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      state                <= cqpm_pkg::CQPM_S_IDLE;
      band_q <= 2'h0; qam_q <= 1'b0; nsym_q <= 10'h000; sym_j <= 10'h000;
      act_q  <= 72'h0; mact_q <= 7'h00; pil_mask <= 72'h0;
      pos    <= 7'h00; base <= 7'h00; acc <= 7'h00; first_pil <= 1'b0;
      car_k  <= 7'h00; act_a <= 7'h00; ref_mode <= 1'b0; ref_cnt <= 1'b0;
      is_ack <= 1'b0;
      frame_tx_confirm_out <= 1'b0;
      frame_tx_status_out  <= `CQPM_ST_SUCCESS;
      ack_tx_confirm_out   <= 1'b0;
      ack_tx_status_out    <= `CQPM_ST_SUCCESS;
      tx_busy_out          <= 1'b0;
    end
    else
    begin
      frame_tx_confirm_out <= 1'b0;
      ack_tx_confirm_out   <= 1'b0;
      unique case (state)
        cqpm_pkg::CQPM_S_IDLE:
        begin
          // frame request: listening first, then validity
          if (frame_tx_request_in)
          begin
            if (receive_listen_state_in)
            begin
              frame_tx_confirm_out <= 1'b1;
              frame_tx_status_out  <= `CQPM_ST_BUSY_RX;
            end
            else if (frame_bad)
            begin
              frame_tx_confirm_out <= 1'b1;
              frame_tx_status_out  <= `CQPM_ST_FAILED;
            end
            else
            begin
              band_q    <= band_sel_in;
              qam_q     <= frame_qam16_in;
              nsym_q    <= frame_data_symbols_in;
              act_q     <= carrier_active_in & lk_range;
              mact_q    <= req_mact;
              sym_j     <= 10'h000;
              pil_mask  <= 72'h0;
              pos       <= lk_off;
              acc       <= 7'h00;
              first_pil <= 1'b1;
              car_k     <= 7'h00;
              act_a     <= 7'h00;
              ref_mode  <= 1'b1;
              ref_cnt   <= 1'b0;
              is_ack    <= 1'b0;
              tx_busy_out <= 1'b1;
              state     <= cqpm_pkg::CQPM_S_SCAN;
            end
          end
          // ack request; a frame taken in the same cycle makes it busy
          if (ack_tx_request_in)
          begin
            ack_tx_confirm_out <= 1'b1;
            if (receive_listen_state_in)
            begin
              ack_tx_status_out <= `CQPM_ST_BUSY_RX;
            end
            else if (frame_tx_request_in && !frame_bad)
            begin
              ack_tx_status_out <= `CQPM_ST_BUSY_TX;
            end
            else if (lk_m == 7'h00)
            begin
              ack_tx_status_out <= `CQPM_ST_FAILED;
            end
            else
            begin
              ack_tx_confirm_out <= 1'b0;
              band_q      <= band_sel_in;
              is_ack      <= 1'b1;
              tx_busy_out <= 1'b1;
              state       <= cqpm_pkg::CQPM_S_ACK;
            end
          end
        end
        cqpm_pkg::CQPM_S_PLAN:
        begin
          // place pilots i while i*spacing < active count, positions mod count
          if (pos >= mact_q)
          begin
            pos <= pos - mact_q;
          end
          else if (acc < mact_q)
          begin
            pil_mask[pos] <= 1'b1;
            if (first_pil)
            begin
              base <= pos;
            end
            first_pil <= 1'b0;
            pos <= pos + lk_sp;
            acc <= acc + lk_sp;
          end
          else
          begin
            state <= cqpm_pkg::CQPM_S_SCAN;
          end
        end
        cqpm_pkg::CQPM_S_SCAN:
        begin
          if (can_go)
          begin
            if (cur_act)
            begin
              act_a <= act_a + 7'h01;
            end
            if (car_k == lk_m - 7'h01)
            begin
              car_k <= 7'h00;
              act_a <= 7'h00;
              if (ref_mode)
              begin
                // inverted reference, then normal, then first data plan
                ref_cnt <= 1'b1;
                if (ref_cnt)
                begin
                  ref_mode <= 1'b0;
                  state    <= cqpm_pkg::CQPM_S_PLAN;
                end
              end
              else if (sym_j == nsym_q - 10'h001)
              begin
                state <= cqpm_pkg::CQPM_S_DRAIN;
              end
              else
              begin
                sym_j     <= sym_j + 10'h001;
                pil_mask  <= 72'h0;
                pos       <= base + `CQPM_SYM_STEP;
                acc       <= 7'h00;
                first_pil <= 1'b1;
                state     <= cqpm_pkg::CQPM_S_PLAN;
              end
            end
            else
            begin
              car_k <= car_k + 7'h01;
            end
          end
        end
        cqpm_pkg::CQPM_S_ACK:
        begin
          if (push_ok)
          begin
            state <= cqpm_pkg::CQPM_S_DRAIN;
          end
        end
        cqpm_pkg::CQPM_S_DRAIN:
        begin
          // success once every word has left the buffer
          if (!sym_valid_out && !buf1_v)
          begin
            tx_busy_out <= 1'b0;
            state       <= cqpm_pkg::CQPM_S_IDLE;
            if (is_ack)
            begin
              ack_tx_confirm_out <= 1'b1;
              ack_tx_status_out  <= `CQPM_ST_SUCCESS;
            end
            else
            begin
              frame_tx_confirm_out <= 1'b1;
              frame_tx_status_out  <= `CQPM_ST_SUCCESS;
            end
          end
        end
      endcase
      // requests while transmitting are refused, listening taking precedence; a same-kind request in the final drain cycle sees only the success confirm
      if (state != cqpm_pkg::CQPM_S_IDLE && frame_tx_request_in && !(state == cqpm_pkg::CQPM_S_DRAIN
          && !is_ack && !sym_valid_out && !buf1_v))
      begin
        frame_tx_confirm_out <= 1'b1;
        frame_tx_status_out  <= receive_listen_state_in ? `CQPM_ST_BUSY_RX : `CQPM_ST_BUSY_TX;
      end
      if (state != cqpm_pkg::CQPM_S_IDLE && ack_tx_request_in && !(state == cqpm_pkg::CQPM_S_DRAIN
          && is_ack && !sym_valid_out && !buf1_v))
      begin
        ack_tx_confirm_out <= 1'b1;
        ack_tx_status_out  <= receive_listen_state_in ? `CQPM_ST_BUSY_RX : `CQPM_ST_BUSY_TX;
      end
    end
  end

endmodule

//--- shared/cqpm_defines.svh
// Purpose: constants of the coherent mapping and pilot insertion stage
// Assumes: 25 MHz core clock, tone list of at most 72 carriers
// Notes: amplitudes are signed 16-bit, full unit is 16384
`ifndef CQPM_DEFINES_SVH
`define CQPM_DEFINES_SVH

// band select codes
`define CQPM_BAND_CEN_A   2'h0
`define CQPM_BAND_CEN_B   2'h1
`define CQPM_BAND_FCC     2'h2

// carriers per symbol
`define CQPM_M_CEN_A      7'h24
`define CQPM_M_CEN_B      7'h10
`define CQPM_M_FCC        7'h48

// pilot spacing in carrier spacings
`define CQPM_SP_CEN_A     7'h0c
`define CQPM_SP_CEN_B     7'h08
`define CQPM_SP_FCC       7'h0c

// pilot position offset
`define CQPM_OFF_CEN      7'h06
`define CQPM_OFF_FCC      7'h24

// absolute bin of the first carrier
`define CQPM_FIRST_CEN_A  8'h17
`define CQPM_FIRST_CEN_B  8'h3f
`define CQPM_FIRST_FCC    8'h21

// per-symbol pilot start advance
`define CQPM_SYM_STEP     7'h02

// confirm status codes
`define CQPM_ST_SUCCESS   2'h0
`define CQPM_ST_BUSY_RX   2'h1
`define CQPM_ST_BUSY_TX   2'h2
`define CQPM_ST_FAILED    2'h3

// unit amplitude for psk points
`define CQPM_UNIT         16'sh4000
// 16-qam levels: 1 and 3 times unit over sqrt(10), rounded
`define CQPM_QAM_L1       16'sh143d
`define CQPM_QAM_L3       16'sh3cb7

`endif

//--- shared/cqpm_pkg.sv
// Purpose: types shared by the mapping stage and its bench
// Assumes: constants come from cqpm_defines.svh
// Notes: one word of the output stream is one mapped carrier
package cqpm_pkg;

  // what a stream word carries
  typedef enum logic [2:0] {
    CQPM_KIND_DATA,
    CQPM_KIND_PILOT,
    CQPM_KIND_REF_INV,
    CQPM_KIND_REF,
    CQPM_KIND_ACK
  } cqpm_kind_e;

  // one mapped carrier toward the ofdm modulator
  typedef struct packed {
    cqpm_kind_e         kind;
    logic               sym_start;
    logic [7:0]         bin;
    logic signed [15:0] re;
    logic signed [15:0] im;
  } cqpm_word_s;

  // control sequence of the mapper
  typedef enum logic [2:0] {
    CQPM_S_IDLE,
    CQPM_S_PLAN,
    CQPM_S_SCAN,
    CQPM_S_ACK,
    CQPM_S_DRAIN
  } cqpm_state_e;

endpackage

//--- tb/cqpm_mac_model.sv
// Purpose: payload nibble and pilot pn pair feeder
// Assumes: valid/ready takes on rising edges
// Notes: data prompt, pn slow (one idle cycle per take)
`timescale 1ns/1ps
module cqpm_mac_model (
  // clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       rst_in,
  // payload nibbles
  input  wire logic       data_ready_in,
  output logic            data_valid_out,
  output logic [3:0]      data_bits_out,
  // pilot pairs
  input  wire logic       pn_ready_in,
  output logic            pn_valid_out,
  output logic [1:0]      pn_bits_out
);
  // counting nibbles walk every data code; held until taken
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      data_valid_out <= 1'h0;
      data_bits_out  <= 4'h0;
    end
    else if (!data_valid_out || data_ready_in)
    begin
      data_valid_out <= 1'h1;
      data_bits_out  <= data_bits_out + 4'h1;
    end
  end
  // pair with earlier bit 1 in bit0: a quarter-turn pilot
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in || (pn_valid_out && pn_ready_in))
    begin
      pn_valid_out <= 1'h0;
      pn_bits_out  <= 2'h2; // released: inverse of the pair
    end
    else
    begin
      pn_valid_out <= 1'h1;
      pn_bits_out  <= 2'h1;
    end
  end
endmodule

//--- tb/cqpm_mapper_tx_checker.sv
// Purpose: port assertions of the coherent mapper
// Assumes: one clock, synchronous active-high reset
// Notes: bound to every mapper instance below
`timescale 1ns/1ps
`include "cqpm_defines.svh"
module cqpm_mapper_tx_checker (
  // clock and reset
  input wire logic                 core_clk_in,
  input wire logic                 rst_in,
  // requests and levels
  input wire logic [1:0]           band_sel_in,
  input wire logic                 receive_listen_state_in,
  input wire logic                 frame_tx_request_in,
  input wire logic                 frame_qam16_in,
  input wire logic [9:0]           frame_data_symbols_in,
  input wire logic                 ack_tx_request_in,
  input wire logic                 sym_ready_in,
  // answers and stream
  input wire logic                 frame_tx_confirm_out,
  input wire logic [1:0]           frame_tx_status_out,
  input wire logic                 ack_tx_confirm_out,
  input wire logic [1:0]           ack_tx_status_out,
  input wire logic                 tx_busy_out,
  input wire logic                 sym_valid_out,
  input wire cqpm_pkg::cqpm_word_s sym_word_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  // frame request met by an idle mapper
  logic fr_idle;
  assign fr_idle = frame_tx_request_in && !tx_busy_out;
  property p_f_rx;
    fr_idle && receive_listen_state_in |=> frame_tx_confirm_out && frame_tx_status_out == `CQPM_ST_BUSY_RX;
  endproperty
  a_f_rx: assert property (p_f_rx) else $error("frame not refused busy rx");
  property p_f_tx;
    frame_tx_request_in && tx_busy_out && !frame_tx_confirm_out && !ack_tx_confirm_out && !receive_listen_state_in
      |=> frame_tx_confirm_out && frame_tx_status_out == `CQPM_ST_BUSY_TX;
  endproperty
  a_f_tx: assert property (p_f_tx) else $error("frame not refused busy tx");
  property p_f_zero;
    fr_idle && !receive_listen_state_in && frame_data_symbols_in == 10'h0
      |=> frame_tx_confirm_out && frame_tx_status_out == `CQPM_ST_FAILED;
  endproperty
  a_f_zero: assert property (p_f_zero) else $error("empty frame not failed");
  property p_f_q16;
    fr_idle && !receive_listen_state_in && frame_qam16_in && band_sel_in != `CQPM_BAND_FCC
      |=> frame_tx_confirm_out && frame_tx_status_out == `CQPM_ST_FAILED;
  endproperty
  a_f_q16: assert property (p_f_q16) else $error("16-qam outside fcc accepted");
  property p_a_rx;
    ack_tx_request_in && !frame_tx_request_in && !tx_busy_out && receive_listen_state_in
      |=> ack_tx_confirm_out && ack_tx_status_out == `CQPM_ST_BUSY_RX;
  endproperty
  a_a_rx: assert property (p_a_rx) else $error("ack not refused busy rx");
  property p_hold;
    !frame_tx_confirm_out |-> $stable(frame_tx_status_out);
  endproperty
  a_hold: assert property (p_hold) else $error("frame status moved without confirm");
  property p_stall;
    sym_valid_out && !sym_ready_in |=> sym_valid_out && $stable(sym_word_out);
  endproperty
  a_stall: assert property (p_stall) else $error("stalled word lost");
  property p_pilot;
    sym_valid_out && sym_word_out.kind == cqpm_pkg::CQPM_KIND_PILOT |->
      {sym_word_out.re, sym_word_out.im} inside {32'h00004000, 32'h0000c000, 32'h40000000, 32'hc0000000};
  endproperty
  a_pilot: assert property (p_pilot) else $error("pilot off the unit qpsk points");
endmodule
bind cqpm_mapper_tx cqpm_mapper_tx_checker u_chk (.*);

//--- tb/cqpm_mapper_tx_tb.sv
// Purpose: self-checking bench of the coherent mapper
// Assumes: partner model feeds payload and pn bits
// Notes: table rows first, then busy and pilot cases
`timescale 1ns/1ps
module cqpm_mapper_tx_tb;
  // one request and the status it should get
  typedef struct packed {
    logic       a;
    logic [1:0] b;
    logic       q;
    logic       s;
    logic       l;
    logic [9:0] n;
    logic [1:0] st;
  } cqpm_row_s;
  logic                 clk = 1'h0;        // core clock
  logic                 rst = 1'h1;        // sync reset
  logic [1:0]           band = 2'h0;       // band code
  logic                 sup = 1'h0;        // 16-qam offered
  logic                 lis = 1'h0;        // receiver listening
  logic [71:0]          act = {72{1'h1}};  // active carriers
  logic                 freq = 1'h0;       // frame request
  logic                 fq16 = 1'h0;       // frame in 16-qam
  logic [9:0]           nsym = 10'h0;      // data symbols
  logic                 areq = 1'h0;       // ack request
  logic                 srdy = 1'h1;       // stream ready
  logic                 stall = 1'h0;      // stall wanted
  logic                 fc, ac, busy, dv, dr, pv, pr, sv;
  logic [1:0]           fs, ast, pb;
  logic [3:0]           db;
  cqpm_pkg::cqpm_word_s sw;
  int                   n_mismatch = 0;
  int                   tests_run = 0;
  logic [7:0]           got[$], exp[$];    // pilot bins seen, wanted
  // ack, band, 16-qam, offered, listening, symbols, status
  cqpm_row_s            rows[9] = '{
    '{1'h0, 2'h1, 1'h0, 1'h0, 1'h1, 10'h1, 2'h1},
    '{1'h0, 2'h1, 1'h0, 1'h0, 1'h0, 10'h0, 2'h3},
    '{1'h0, 2'h3, 1'h0, 1'h0, 1'h0, 10'h1, 2'h3},
    '{1'h0, 2'h0, 1'h1, 1'h1, 1'h0, 10'h1, 2'h3},
    '{1'h0, 2'h2, 1'h1, 1'h0, 1'h0, 10'h1, 2'h3},
    '{1'h0, 2'h2, 1'h1, 1'h1, 1'h0, 10'h1, 2'h0},
    '{1'h1, 2'h1, 1'h0, 1'h0, 1'h1, 10'h1, 2'h1},
    '{1'h1, 2'h3, 1'h0, 1'h0, 1'h0, 10'h1, 2'h3},
    '{1'h1, 2'h1, 1'h0, 1'h0, 1'h0, 10'h1, 2'h0}};
  cqpm_mapper_tx u_dut (
    .core_clk_in(clk), .rst_in(rst), .band_sel_in(band), .qam16_supported_in(sup),
    .receive_listen_state_in(lis), .carrier_active_in(act), .frame_tx_request_in(freq),
    .frame_qam16_in(fq16), .frame_data_symbols_in(nsym), .frame_tx_confirm_out(fc),
    .frame_tx_status_out(fs), .ack_tx_request_in(areq), .ack_tx_confirm_out(ac),
    .ack_tx_status_out(ast), .tx_busy_out(busy), .data_valid_in(dv), .data_bits_in(db),
    .data_ready_out(dr), .pn_valid_in(pv), .pn_bits_in(pb), .pn_ready_out(pr),
    .sym_valid_out(sv), .sym_word_out(sw), .sym_ready_in(srdy));
  cqpm_mac_model u_mac (
    .core_clk_in(clk), .rst_in(rst), .data_ready_in(dr), .data_valid_out(dv),
    .data_bits_out(db), .pn_ready_in(pr), .pn_valid_out(pv), .pn_bits_out(pb));
  initial forever #20 clk = ~clk;
  // ready toggles each cycle while a stall is wanted
  always @(posedge clk) srdy <= !stall || !srdy;
  // collect pilot bins and check their point
  always @(posedge clk)
  begin
    if (sv === 1'h1 && srdy === 1'h1 && sw.kind === cqpm_pkg::CQPM_KIND_PILOT)
    begin
      got.push_back(sw.bin);
      chk({sw.re, sw.im}, 32'h00004000);
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // one-cycle request with its levels
  task automatic pulse(input cqpm_row_s r);
    @(posedge clk);
    {band, fq16, sup, lis, nsym} <= {r.b, r.q, r.s, r.l, r.n};
    if (r.a) areq <= 1'h1;
    else freq <= 1'h1;
    @(posedge clk);
    {areq, freq} <= 2'h0;
  endtask
  // bounded wait for a confirm, then its status; a refusal stands just after the request edge
  task automatic wait_conf(input logic a, input logic [1:0] st);
    int k = 0;
    #1;
    while ((a ? ac : fc) !== 1'h1 && k < 4000)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    if (k == 4000)
    begin
      n_mismatch++;
      end_of_test;
    end
    else chk(a ? ast : fs, st);
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    #1;
    chk({fc, ac, busy, sv}, 32'h0);
    foreach (rows[i])
    begin
      pulse(rows[i]);
      wait_conf(rows[i].a, rows[i].st);
    end
    // stalled fcc frame: ack and frame requests refused meanwhile
    stall <= 1'h1;
    pulse(rows[5]);
    repeat (10) @(posedge clk);
    pulse(rows[8]);
    wait_conf(1'h1, 2'h2);
    pulse(rows[5]);
    wait_conf(1'h0, 2'h2);
    @(posedge clk);
    wait_conf(1'h0, 2'h0);
    stall <= 1'h0;
    for (int i = 0; i < 12; i++) exp.push_back(8'h21 + 8'(12 * (i % 6)));
    pulse('{1'h0, 2'h1, 1'h0, 1'h0, 1'h0, 10'h2, 2'h0});
    wait_conf(1'h0, 2'h0);
    @(posedge clk);
    act <= {{71{1'h1}}, 1'h0};
    pulse('{1'h0, 2'h1, 1'h0, 1'h0, 1'h0, 10'h1, 2'h0});
    wait_conf(1'h0, 2'h0);
    exp = {exp, 8'h45, 8'h4d, 8'h3f, 8'h47, 8'h46, 8'h4e};
    chk(got.size(), exp.size());
    foreach (exp[i]) if (i < got.size()) chk(got[i], exp[i]);
    end_of_test;
  end
endmodule
